/* fcvd_top.sv */
// Flash command validity decoder with Wishbone register slave
`timescale 1ns/1ps
`include "fcvd_defs.svh"
module fcvd_top
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input fcvd_pkg::fcvd_wb_req_s wb_req_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  input wire logic normal_single_chip_in,
  input wire logic secured_in,
  input wire logic once_field_written_in,
  input wire logic array_done_in,
  output fcvd_pkg::fcvd_arr_req_s arr_req_out,
  output logic [6:0] nvm_clock_divider_out
);
  import fcvd_pkg::*;

  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic [7:0] command_code_q;
  logic tgt_ee_q;
  logic command_complete_flag_q;
  logic access_error_flag_q;
  logic pviol_q;
  logic divld_q;
  logic [6:0] div_q;
  logic [2:0] pflash_protection_reg_q;
  fcvd_arr_req_s arr_q;
  fcvd_arr_req_s arr_d;

  logic acc;
  logic wr;
  logic hit_cmd;
  logic hit_stat;
  logic hit_div;
  logic hit_prot;
  logic hit_mode;
  logic idle;
  logic permitted;
  logic prog_erase;
  logic needs_prot;
  fcvd_op_e op;
  logic launch_req;
  logic bad_cmd;
  logic no_div;
  logic once_used;
  logic prot_open;
  logic prot_bad;
  logic acc_fault;
  logic go;
  logic err_set;
  logic err_clr;
  logic pv_set;
  logic pv_clr;

  // Code lookup kept apart so the table can be reviewed on its own
  fcvd_cmd_table u_table
  (
    .code_in(command_code_q),
    .normal_in(normal_single_chip_in),
    .secured_in(secured_in),
    .eeprom_in(tgt_ee_q),
    .permitted_out(permitted),
    .prog_erase_out(prog_erase),
    .needs_prot_out(needs_prot),
    .op_out(op)
  );

  // Bus access: one cycle to ack, ack forced low for a cycle after
  assign acc = wb_req_in.cyc && wb_req_in.stb && !ack_q;
  assign wr = acc && wb_req_in.we && wb_req_in.sel[0];
  assign idle = command_complete_flag_q;

  // Address decode
  always_comb
  begin
    hit_cmd = 1'b0;
    hit_stat = 1'b0;
    hit_div = 1'b0;
    hit_prot = 1'b0;
    hit_mode = 1'b0;
    if (wb_req_in.adr == `FCVD_OFF_CMD)
      hit_cmd = 1'b1;
    else if (wb_req_in.adr == `FCVD_OFF_STAT)
      hit_stat = 1'b1;
    else if (wb_req_in.adr == `FCVD_OFF_CLKDIV)
      hit_div = 1'b1;
    else if (wb_req_in.adr == `FCVD_OFF_PROT)
      hit_prot = 1'b1;
    else if (wb_req_in.adr == `FCVD_OFF_MODE)
      hit_mode = 1'b1;
  end

  // Read data; unmapped offsets answer with zero
  always_comb
  begin
    dat_d = `FCVD_DAT_RST;
    if (hit_cmd)
    begin
      dat_d[7:0] = command_code_q;
      dat_d[`FCVD_CMD_EE_BIT] = tgt_ee_q;
    end
    else if (hit_stat)
    begin
      dat_d[`FCVD_ST_DONE] = command_complete_flag_q;
      dat_d[`FCVD_ST_ACC_ERR] = access_error_flag_q;
      dat_d[`FCVD_ST_PVIOL] = pviol_q;
      dat_d[`FCVD_ST_DIVLD] = divld_q;
    end
    else if (hit_div)
      dat_d[6:0] = div_q;
    else if (hit_prot)
      dat_d[2:0] = pflash_protection_reg_q;
    else if (hit_mode)
    begin
      dat_d[`FCVD_MD_NORMAL] = normal_single_chip_in;
      dat_d[`FCVD_MD_SECURED] = secured_in;
      dat_d[`FCVD_MD_ONCE] = once_field_written_in;
    end
  end

  // Launch only from idle with no error pending; otherwise ignored
  assign launch_req = wr && hit_stat && wb_req_in.dat[`FCVD_ST_DONE] &&
                      idle && !access_error_flag_q && !pviol_q;

  // Checks made at launch
  assign bad_cmd = !permitted;
  assign no_div = prog_erase && !divld_q;
  assign once_used = (op == FCVD_OP_PROG_ONCE) && once_field_written_in;
  assign prot_open = &pflash_protection_reg_q;
  assign prot_bad = needs_prot && !prot_open;
  assign acc_fault = bad_cmd || no_div || once_used;
  assign go = launch_req && !acc_fault && !prot_bad;

  // Flag set and clear terms; a set in the clearing cycle wins
  assign err_set = launch_req && acc_fault;
  assign pv_set = launch_req && !acc_fault && prot_bad;
  assign err_clr = wr && hit_stat && wb_req_in.dat[`FCVD_ST_ACC_ERR];
  assign pv_clr = wr && hit_stat && wb_req_in.dat[`FCVD_ST_PVIOL];

  // Start strobe toward the array carries the decoded operation
  always_comb
  begin
    arr_d = arr_q;
    arr_d.valid = go;
    if (go)
    begin
      arr_d.op = op;
      arr_d.code = command_code_q;
      arr_d.eeprom = tgt_ee_q;
    end
  end

  // Bus handshake registers
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      ack_q <= 1'b0;
      dat_q <= `FCVD_DAT_RST;
    end
    else
    begin
      ack_q <= acc;
      dat_q <= acc ? dat_d : dat_q;
    end
  end

  // Command code and target; frozen while a command runs
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      command_code_q <= `FCVD_CMD_RST;
      tgt_ee_q <= 1'b0;
    end
    else if (wr && hit_cmd && idle)
    begin
      command_code_q <= wb_req_in.dat[7:0];
      tgt_ee_q <= wb_req_in.sel[1] ? wb_req_in.dat[`FCVD_CMD_EE_BIT]
                                   : tgt_ee_q;
    end
  end

  // Completion flag: cleared by a good launch, set by the array
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      command_complete_flag_q <= 1'b1;
    else if (go)
      command_complete_flag_q <= 1'b0;
    else if (array_done_in)
      command_complete_flag_q <= 1'b1;
  end

  // Error flags, write one to clear
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      access_error_flag_q <= 1'b0;
      pviol_q <= 1'b0;
    end
    else
    begin
      access_error_flag_q <= err_set || (access_error_flag_q && !err_clr);
      pviol_q <= pv_set || (pviol_q && !pv_clr);
    end
  end

  // Divider and protection; changes refused mid-command to keep timing
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      div_q <= `FCVD_DIV_RST;
      divld_q <= 1'b0;
      pflash_protection_reg_q <= `FCVD_PROT_RST;
    end
    else
    begin
      if (wr && hit_div && idle)
      begin
        div_q <= wb_req_in.dat[6:0];
        divld_q <= 1'b1;
      end
      if (wr && hit_prot && idle)
        pflash_protection_reg_q <= wb_req_in.dat[2:0];
    end
  end

  // Array request register
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      arr_q <= '{valid: 1'b0, op: FCVD_OP_NONE, code: `FCVD_CMD_RST,
                 eeprom: 1'b0};
    else
      arr_q <= arr_d;
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;
  assign arr_req_out = arr_q;
  assign nvm_clock_divider_out = div_q;

  // Checks on launch outcomes and on the bus ack
  sequence s_refused;
    access_error_flag_q && command_complete_flag_q && !arr_q.valid;
  endsequence

  sequence s_started;
    arr_q.valid && !command_complete_flag_q;
  endsequence

  a_secured_special: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    launch_req && secured_in && !normal_single_chip_in |=> s_refused)
    else $error("command ran in secured special mode");

  a_mode_table: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    launch_req && !permitted |=> s_refused ##1 command_complete_flag_q)
    else $error("unpermitted command was not refused");

  a_erase_all_gate: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    arr_q.valid && arr_q.op == FCVD_OP_ERS_ALL |->
      !$past(secured_in) && !$past(normal_single_chip_in) &&
      $past(prot_open))
    else $error("erase all started without open protection");

  a_block_prot: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    launch_req && !acc_fault && op == FCVD_OP_ERS_BLK && !tgt_ee_q &&
      !prot_open |=> pviol_q && command_complete_flag_q && !arr_q.valid)
    else $error("block erase ran with protection closed");

  a_unsecure_mode: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    arr_q.valid && arr_q.op == FCVD_OP_UNSEC |->
      !$past(secured_in) && !$past(normal_single_chip_in))
    else $error("unsecure ran outside unsecured special mode");

  a_backdoor_mode: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    arr_q.valid && arr_q.op == FCVD_OP_BACKDOOR |->
      $past(normal_single_chip_in))
    else $error("backdoor key check ran outside normal mode");

  a_field_margin: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    arr_q.valid && arr_q.op == FCVD_OP_FLD_MARG |->
      !$past(secured_in) && !$past(normal_single_chip_in))
    else $error("field margin ran outside unsecured special mode");

  a_user_margin: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    launch_req && command_code_q == `FCVD_C_USR_MARG && divld_q &&
      (normal_single_chip_in || !secured_in) |=> s_started)
    else $error("user margin refused in a permitted state");

  a_once_single: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    launch_req && op == FCVD_OP_PROG_ONCE && once_field_written_in
      |=> s_refused)
    else $error("program once ran a second time");

  a_divider_first: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    launch_req && prog_erase && !divld_q |=> s_refused)
    else $error("program or erase ran before divider write");

  a_invalid_code: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    launch_req && op == FCVD_OP_NONE |=>
      access_error_flag_q [*2] ##0 command_complete_flag_q)
    else $error("invalid command code not flagged");

  a_ack_one_cycle: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held for more than one cycle");
endmodule

/* fcvd_defs.svh */
// Register offsets, bit positions, command codes and reset values
`ifndef FCVD_DEFS_SVH
`define FCVD_DEFS_SVH

// Register byte offsets on the bus
`define FCVD_OFF_CMD 8'h00
`define FCVD_OFF_STAT 8'h04
`define FCVD_OFF_CLKDIV 8'h08
`define FCVD_OFF_PROT 8'h0c
`define FCVD_OFF_MODE 8'h10

// Status register bit positions
`define FCVD_ST_DONE 0
`define FCVD_ST_ACC_ERR 1
`define FCVD_ST_PVIOL 2
`define FCVD_ST_DIVLD 3

// Command register: target select bit above the code byte
`define FCVD_CMD_EE_BIT 8

// Protection register bit positions
`define FCVD_PR_LOW 0
`define FCVD_PR_HIGH 1
`define FCVD_PR_OPEN 2

// Mode register bit positions
`define FCVD_MD_NORMAL 0
`define FCVD_MD_SECURED 1
`define FCVD_MD_ONCE 2

// Command codes
`define FCVD_C_EVFY_ALL 8'h01
`define FCVD_C_EVFY_BLK 8'h02
`define FCVD_C_EVFY_SEC 8'h03
`define FCVD_C_RD_ONCE 8'h04
`define FCVD_C_PROG 8'h06
`define FCVD_C_PROG_ONCE 8'h07
`define FCVD_C_ERS_ALL 8'h08
`define FCVD_C_ERS_BLK 8'h09
`define FCVD_C_ERS_SECT 8'h0a
`define FCVD_C_UNSEC 8'h0b
`define FCVD_C_BACKDOOR 8'h0c
`define FCVD_C_USR_MARG 8'h0d
`define FCVD_C_FLD_MARG 8'h0e
`define FCVD_C_EE_EVFY 8'h10
`define FCVD_C_EE_PROG 8'h11
`define FCVD_C_EE_ERS 8'h12
`define FCVD_C_PROT_OVR 8'h13

// Permission mask bits: unsecured normal, unsecured special, secured normal
`define FCVD_M_NONE 3'h0
`define FCVD_M_ALL 3'h7
`define FCVD_M_USS 3'h2
`define FCVD_M_NORM 3'h5
`define FCVD_M_UN 3'h1
`define FCVD_M_SN 3'h4

// Reset values
`define FCVD_CMD_RST 8'h00
`define FCVD_DIV_RST 7'h00
`define FCVD_PROT_RST 3'h0
`define FCVD_DAT_RST 32'h0000_0000

`endif

/* fcvd_pkg.sv */
// Types shared by the command validity decoder files
package fcvd_pkg;

  typedef enum logic [4:0] {
    FCVD_OP_NONE, FCVD_OP_EVFY_ALL, FCVD_OP_EVFY_BLK, FCVD_OP_EVFY_SEC,
    FCVD_OP_RD_ONCE, FCVD_OP_PROG, FCVD_OP_PROG_ONCE, FCVD_OP_ERS_ALL,
    FCVD_OP_ERS_BLK, FCVD_OP_ERS_SECT, FCVD_OP_UNSEC, FCVD_OP_BACKDOOR,
    FCVD_OP_USR_MARG, FCVD_OP_FLD_MARG, FCVD_OP_EE_EVFY, FCVD_OP_EE_PROG,
    FCVD_OP_EE_ERS, FCVD_OP_PROT_OVR
  } fcvd_op_e;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } fcvd_wb_req_s;

  // Launch toward the memory array sequencer
  typedef struct packed {
    logic valid;
    fcvd_op_e op;
    logic [7:0] code;
    logic eeprom;
  } fcvd_arr_req_s;

endpackage

/* fcvd_cmd_table.sv */
// Command code lookup: permission by mode and security, and command class
`timescale 1ns/1ps
`include "fcvd_defs.svh"
module fcvd_cmd_table
(
  input wire logic [7:0] code_in,
  input wire logic normal_in,
  input wire logic secured_in,
  input wire logic eeprom_in,
  output logic permitted_out,
  output logic prog_erase_out,
  output logic needs_prot_out,
  output fcvd_pkg::fcvd_op_e op_out
);
  import fcvd_pkg::*;

  // Mask of states in which a code may run; zero for unknown codes
  function automatic logic [2:0] mask_of(input logic [7:0] c);
    case (c)
      `FCVD_C_ERS_ALL, `FCVD_C_UNSEC, `FCVD_C_FLD_MARG: mask_of = `FCVD_M_USS;
      `FCVD_C_BACKDOOR, `FCVD_C_PROT_OVR: mask_of = `FCVD_M_NORM;
      `FCVD_C_EVFY_ALL, `FCVD_C_EVFY_BLK, `FCVD_C_EVFY_SEC, `FCVD_C_RD_ONCE,
      `FCVD_C_PROG, `FCVD_C_PROG_ONCE, `FCVD_C_ERS_BLK, `FCVD_C_ERS_SECT,
      `FCVD_C_USR_MARG, `FCVD_C_EE_EVFY, `FCVD_C_EE_PROG,
      `FCVD_C_EE_ERS: mask_of = `FCVD_M_ALL;
      default: mask_of = `FCVD_M_NONE;
    endcase
  endfunction

  // Operation each code starts in the array
  function automatic fcvd_op_e op_of(input logic [7:0] c);
    case (c)
      `FCVD_C_EVFY_ALL: op_of = FCVD_OP_EVFY_ALL;
      `FCVD_C_EVFY_BLK: op_of = FCVD_OP_EVFY_BLK;
      `FCVD_C_EVFY_SEC: op_of = FCVD_OP_EVFY_SEC;
      `FCVD_C_RD_ONCE: op_of = FCVD_OP_RD_ONCE;
      `FCVD_C_PROG: op_of = FCVD_OP_PROG;
      `FCVD_C_PROG_ONCE: op_of = FCVD_OP_PROG_ONCE;
      `FCVD_C_ERS_ALL: op_of = FCVD_OP_ERS_ALL;
      `FCVD_C_ERS_BLK: op_of = FCVD_OP_ERS_BLK;
      `FCVD_C_ERS_SECT: op_of = FCVD_OP_ERS_SECT;
      `FCVD_C_UNSEC: op_of = FCVD_OP_UNSEC;
      `FCVD_C_BACKDOOR: op_of = FCVD_OP_BACKDOOR;
      `FCVD_C_USR_MARG: op_of = FCVD_OP_USR_MARG;
      `FCVD_C_FLD_MARG: op_of = FCVD_OP_FLD_MARG;
      `FCVD_C_EE_EVFY: op_of = FCVD_OP_EE_EVFY;
      `FCVD_C_EE_PROG: op_of = FCVD_OP_EE_PROG;
      `FCVD_C_EE_ERS: op_of = FCVD_OP_EE_ERS;
      `FCVD_C_PROT_OVR: op_of = FCVD_OP_PROT_OVR;
      default: op_of = FCVD_OP_NONE;
    endcase
  endfunction

  logic [2:0] mask;
  logic [2:0] state_bit;

  // One-hot of the current state; secured special selects nothing
  assign state_bit = secured_in ? (normal_in ? `FCVD_M_SN : `FCVD_M_NONE)
                                : (normal_in ? `FCVD_M_UN : `FCVD_M_USS);
  assign mask = mask_of(code_in);
  assign permitted_out = |(mask & state_bit);
  assign op_out = op_of(code_in);

  // Program and erase commands need the divider written first
  assign prog_erase_out = (op_out == FCVD_OP_PROG) ||
                          (op_out == FCVD_OP_PROG_ONCE) ||
                          (op_out == FCVD_OP_ERS_ALL) ||
                          (op_out == FCVD_OP_ERS_BLK) ||
                          (op_out == FCVD_OP_ERS_SECT) ||
                          (op_out == FCVD_OP_UNSEC) ||
                          (op_out == FCVD_OP_EE_PROG) ||
                          (op_out == FCVD_OP_EE_ERS);

  // Mass erase and a full program-flash block erase need open protection
  assign needs_prot_out = (op_out == FCVD_OP_ERS_ALL) ||
                          ((op_out == FCVD_OP_ERS_BLK) && !eeprom_in);
endmodule

/* fcvd_top_bench.sv */
// Self-checking bench for the flash command validity decoder
`timescale 1ns/1ps
`include "fcvd_defs.svh"
module fcvd_top_bench;
  import fcvd_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  fcvd_wb_req_s req = '0;
  logic normal_in = 1'b1;
  logic secured_in = 1'b0;
  logic once_in = 1'b0;
  logic done_in = 1'b0;
  logic wb_ack_out;
  logic [31:0] wb_dat_out;
  fcvd_arr_req_s arr_out;
  logic [6:0] div_out;
  integer error_cnt = 0;
  integer cmp_count = 0;
  integer seed = 87;
  logic [32:0] q_rd[$];
  logic [13:0] q_arr[$];
  logic [32:0] rd_note;
  logic [6:0] div_v;
  logic [7:0] codes[21] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11,
    8'h12, 8'h13, 8'h14, 8'hff};

  fcvd_top u_fcvd_top (.clk_in(clk_in), .resetn_in(resetn_in),
    .wb_req_in(req), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .normal_single_chip_in(normal_in), .secured_in(secured_in),
    .once_field_written_in(once_in), .array_done_in(done_in),
    .arr_req_out(arr_out), .nvm_clock_divider_out(div_out));

  // 25 MHz clock
  initial
  begin
    forever #20 clk_in = ~clk_in;
  end

  // Count one comparison and report a mismatch at once
  task automatic cmp(input logic ok, input string what);
    cmp_count++;
    if (!ok)
    begin
      error_cnt++;
      $display("ERROR at %0t: %s mismatch", $time, what);
    end
  endtask

  task automatic cmp_rd(input logic [31:0] exp, input logic [31:0] got);
    cmp(got === exp, "read data");
  endtask

  task automatic cmp_arr(input logic [13:0] exp, input logic [13:0] got);
    cmp(got === exp, "array launch");
  endtask

  // One classic cycle; waits for ack, an unbounded wait cut by the watchdog
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic chk, input logic [31:0] exp);
    q_rd.push_back({chk, exp});
    @(posedge clk_in);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    do @(posedge clk_in); while (wb_ack_out !== 1'b1);
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 1'b0, 32'h0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000, 1'b1, exp);
  endtask

  // Sequencer finish pulse; flag returns the cycle after
  task automatic finish_array();
    @(posedge clk_in);
    done_in <= 1'b1;
    @(posedge clk_in);
    done_in <= 1'b0;
  endtask

  // Load and launch; st of zero means a good launch, else refused status
  task automatic launch(input logic [7:0] c, input logic ee,
    input logic [31:0] st);
    wr(`FCVD_OFF_CMD, {23'h0, ee, c});
    if (st == 32'h0)
      q_arr.push_back({exp_op(c), ee, c});
    wr(`FCVD_OFF_STAT, 32'h0000_0001);
    rd(`FCVD_OFF_STAT, (st == 32'h0) ? 32'h0000_0008 : st);
    if (st == 32'h0)
    begin
      finish_array();
      rd(`FCVD_OFF_STAT, 32'h0000_0009);
    end
    else
      wr(`FCVD_OFF_STAT, st & 32'h0000_0006);
  endtask

  // Operation each code should start, kept apart from the design's table
  function automatic fcvd_op_e exp_op(input logic [7:0] c);
    case (c)
      8'h01: return FCVD_OP_EVFY_ALL;
      8'h02: return FCVD_OP_EVFY_BLK;
      8'h03: return FCVD_OP_EVFY_SEC;
      8'h04: return FCVD_OP_RD_ONCE;
      8'h06: return FCVD_OP_PROG;
      8'h07: return FCVD_OP_PROG_ONCE;
      8'h08: return FCVD_OP_ERS_ALL;
      8'h09: return FCVD_OP_ERS_BLK;
      8'h0a: return FCVD_OP_ERS_SECT;
      8'h0b: return FCVD_OP_UNSEC;
      8'h0c: return FCVD_OP_BACKDOOR;
      8'h0d: return FCVD_OP_USR_MARG;
      8'h0e: return FCVD_OP_FLD_MARG;
      8'h10: return FCVD_OP_EE_EVFY;
      8'h11: return FCVD_OP_EE_PROG;
      8'h12: return FCVD_OP_EE_ERS;
      8'h13: return FCVD_OP_PROT_OVR;
      default: return FCVD_OP_NONE;
    endcase
  endfunction

  // Permission by mode and security, worked out independently
  function automatic logic perm(input logic [7:0] c, input logic n,
    input logic s);
    if (s && !n)
      return 1'b0;
    case (c)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d,
      8'h10, 8'h11, 8'h12: return 1'b1;
      8'h08, 8'h0b, 8'h0e: return !n && !s;
      8'h0c, 8'h13: return n;
      default: return 1'b0;
    endcase
  endfunction

  // Result watcher: takes the oldest note whenever an answer appears
  always @(posedge clk_in)
  begin
    if (wb_ack_out === 1'b1)
    begin
      if (q_rd.size() == 0)
        cmp(1'b0, "unexpected ack");
      else
      begin
        rd_note = q_rd.pop_front();
        if (rd_note[32])
          cmp_rd(rd_note[31:0], wb_dat_out);
      end
    end
    if (arr_out.valid === 1'b1)
    begin
      if (q_arr.size() == 0)
        cmp(1'b0, "unexpected launch");
      else
        cmp_arr(q_arr.pop_front(),
          {arr_out.op, arr_out.eeprom, arr_out.code});
    end
  end

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic set_mode(input logic n, input logic s, input logic o);
    @(posedge clk_in);
    normal_in <= n;
    secured_in <= s;
    once_in <= o;
  endtask

  task automatic finish_test();
    if (q_rd.size() != 0 || q_arr.size() != 0)
      error_cnt++;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog sized well beyond the thousand-odd cycles the tests need
  initial
  begin
    #(40 * 20000);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(`FCVD_OFF_STAT, 32'h0000_0001);
    rd(`FCVD_OFF_MODE, 32'h0000_0001);
    wr(8'h20, $random(seed));
    rd(8'h20, 32'h0000_0000);
    end_test("reset_and_unmapped");
    launch(8'h06, 1'b0, 32'h0000_0003);
    div_v = 7'($random(seed));
    wr(`FCVD_OFF_CLKDIV, {25'h0, div_v});
    cmp(div_out === div_v, "divider");
    rd(`FCVD_OFF_STAT, 32'h0000_0009);
    end_test("divider");
    wr(`FCVD_OFF_PROT, 32'h0000_0007);
    for (int st = 0; st < 4; st++)
    begin
      set_mode(st[0], st[1], 1'b0);
      rd(`FCVD_OFF_MODE, {30'h0, st[1], st[0]});
      foreach (codes[i])
        launch(codes[i], codes[i] inside {8'h11, 8'h12},
          perm(codes[i], st[0], st[1]) ? 32'h0 : 32'h0000_000b);
    end
    end_test("permission_table");
    set_mode(1'b0, 1'b0, 1'b0);
    wr(`FCVD_OFF_PROT, 32'h0000_0003);
    launch(8'h08, 1'b0, 32'h0000_000d);
    wr(`FCVD_OFF_PROT, 32'h0000_0006);
    launch(8'h09, 1'b0, 32'h0000_000d);
    launch(8'h09, 1'b1, 32'h0);
    end_test("protection");
    set_mode(1'b1, 1'b0, 1'b1);
    launch(8'h07, 1'b0, 32'h0000_000b);
    launch(8'h04, 1'b0, 32'h0);
    end_test("once_field");
    wr(`FCVD_OFF_CMD, 32'h0000_00ee);
    wr(`FCVD_OFF_STAT, 32'h0000_0001);
    wr(`FCVD_OFF_STAT, 32'h0000_0001);
    rd(`FCVD_OFF_STAT, 32'h0000_000b);
    wr(`FCVD_OFF_STAT, 32'h0000_0002);
    q_arr.push_back({exp_op(8'h06), 1'b0, 8'h06});
    wr(`FCVD_OFF_CMD, 32'h0000_0006);
    wr(`FCVD_OFF_STAT, 32'h0000_0001);
    wr(`FCVD_OFF_CMD, 32'h0000_000a);
    rd(`FCVD_OFF_CMD, 32'h0000_0006);
    rd(`FCVD_OFF_STAT, 32'h0000_0008);
    finish_array();
    rd(`FCVD_OFF_STAT, 32'h0000_0009);
    end_test("busy_and_pending_error");
    // Mid-run reset must forget the divider write again
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    cmp(div_out === 7'h00, "divider after reset");
    rd(`FCVD_OFF_STAT, 32'h0000_0001);
    launch(8'h06, 1'b0, 32'h0000_0003);
    end_test("mid_run_reset");
    repeat (4) @(posedge clk_in);
    finish_test();
  end
endmodule
